/* src/motor_error_response_cfg.svh */
// constants of the motor error response block
`ifndef MOTOR_ERROR_RESPONSE_CFG_SVH
`define MOTOR_ERROR_RESPONSE_CFG_SVH
`define NUM_ERR       8
`define OFS_RESP      8'h00
`define OFS_CTRL      8'h04
`define OFS_STATUS    8'h08
`define OFS_OCC       8'h0c
`define OFS_ERRVAR    8'h10
`define RESP_RST      16'h5555
`define COAST_RST     1'b0
`define COAST_BIT     0
`define STAT_AWAIT    8
`define STAT_DRIVE    9
`define STAT_OFF      10
`define ERR_LIMIT     16'h0fff
`define DUTY_MAX      10'h258
`define MCLK_HZ       20000000
`define HB_PERIOD_MS  1000
`define HB_PULSE_MS   100
`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2
`endif

/* src/motor_error_response_pkg.sv */
// types shared by the motor error response block
package motor_error_response_pkg;
  typedef enum logic [1:0] {resp_disabled, resp_enabled, resp_latched} resp_e;
  typedef logic signed [10:0] duty_t;
  typedef logic signed [12:0] errvar_t;
endpackage

/* src/drive_if.sv */
// drive request from the response logic to the bridge driver
interface drive_if;
  import motor_error_response_pkg::*;
  logic  drive_en;
  logic  coast;
  duty_t duty;
  modport ctl (output drive_en, output coast, output duty);
  modport drv (input drive_en, input coast, input duty);
endinterface

/* src/bridge_drive.sv */
// h-bridge pwm and idle output driver
`include "motor_error_response_cfg.svh"
module bridge_drive (
  input  wire logic mclk,
  input  wire logic rst_sync_n,
  drive_if.drv      d,
  output logic      out_a,
  output logic      out_a_oe,
  output logic      out_b,
  output logic      out_b_oe
);
  import motor_error_response_pkg::*;
  typedef struct packed {
    logic [9:0] cnt;
    logic       a;
    logic       a_oe;
    logic       b;
    logic       b_oe;
  } st_s;
  st_s        s;
  st_s        n;
  logic [9:0] mag;

  always_comb begin
    n = s;
    mag = d.duty[10] ? 10'(-d.duty) : d.duty[9:0];
    n.cnt = (s.cnt == `DUTY_MAX - 10'h001) ? 10'h000 : s.cnt + 10'h001;
    if (d.drive_en && mag != 10'h000 && s.cnt < mag) begin
      n.a = !d.duty[10];
      n.b = d.duty[10];
      n.a_oe = 1'b1;
      n.b_oe = 1'b1;
    end else begin
      // zero duty, off phase or motor off all follow the idle policy
      n.a = 1'b0;
      n.b = 1'b0;
      n.a_oe = !d.coast;
      n.b_oe = !d.coast;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign out_a = s.a;
  assign out_a_oe = s.a_oe;
  assign out_b = s.b;
  assign out_b_oe = s.b_oe;

  sequence idle_brake;
    // the outputs leave reset one edge after the release, so skip that edge
    rst_sync_n && (!d.drive_en || d.duty == 11'sh000) && !d.coast;
  endsequence
  sequence idle_coast;
    rst_sync_n && (!d.drive_en || d.duty == 11'sh000) && d.coast;
  endsequence

  AST_BRAKE_LOW: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    idle_brake |=> (out_a_oe && out_b_oe && !out_a && !out_b))
    else $error("idle brake does not ground both outputs");
  AST_COAST_FLOAT: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    idle_coast |=> (!out_a_oe && !out_b_oe))
    else $error("coast does not float both outputs");
endmodule

/* src/motor_error_response.sv */
// per-error motor response, idle policy, led pattern and axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "motor_error_response_cfg.svh"
module motor_error_response #(
  parameter int HB_PERIOD_CYC = `HB_PERIOD_MS * (`MCLK_HZ / 1000),
  parameter int HB_PULSE_CYC  = `HB_PULSE_MS * (`MCLK_HZ / 1000)
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [7:0]                    err_active,
  input  wire logic                          target_cmd,
  input  wire logic                          motor_off_cmd,
  input  wire logic                          query_occ,
  output logic [7:0]                         occ_flags,
  output logic                               occ_valid,
  input  wire motor_error_response_pkg::duty_t duty_in,
  input  wire logic signed [15:0]            ctrl_err,
  output motor_error_response_pkg::errvar_t  err_var,
  input  wire logic                          fw_replace,
  input  wire logic                          boot_mode,
  input  wire logic                          host_link,
  output logic                               led_green,
  output logic                               out_a,
  output logic                               out_a_oe,
  output logic                               out_b,
  output logic                               out_b_oe
);
  import motor_error_response_pkg::*;

  typedef struct packed {
    logic        aw_done;
    logic [7:0]  aw_addr;
    logic        w_done;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] resp_cfg;
    logic        coast;
    logic        motor_off;
    logic        awaiting;
    logic [7:0]  occurred;
    logic [7:0]  occ_flags;
    logic        occ_valid;
    errvar_t     err_var;
    logic [24:0] hb_cnt;
    logic        led;
  } st_s;

  st_s        s;
  st_s        n;
  logic [1:0] rst_pipe;
  logic       rst_sync_n;
  logic [7:0] en_mask;
  logic [7:0] lat_mask;
  logic       stop_now;
  logic       lat_hit;
  logic       drive_en;
  logic       blink;
  logic [31:0] wr_word;
  drive_if    drv ();

  // async assert, synchronous release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  for (genvar i = 0; i < `NUM_ERR; i++) begin : g_err
    assign en_mask[i] = s.resp_cfg[2*i+1 -: 2] != resp_disabled;
    assign lat_mask[i] = s.resp_cfg[2*i+1 -: 2] == resp_latched;
  end

  assign stop_now = |(err_active & en_mask);
  assign lat_hit = |(err_active & lat_mask);
  // an enabled error that is active while a target arrives keeps the motor off
  assign drive_en = !s.awaiting && !s.motor_off && !stop_now;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] dat, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    n = s;
    n.occ_valid = 1'b0;
    wr_word = 32'h0000_0000;
    // latch set wins over a target command in the same cycle
    if (target_cmd) begin
      n.awaiting = 1'b0;
      n.motor_off = 1'b0;
    end
    if (lat_hit) begin
      n.awaiting = 1'b1;
    end
    if (motor_off_cmd) begin
      n.motor_off = 1'b1;
    end
    // new occurrences survive a query in the same cycle
    n.occurred = s.occurred | err_active;
    if (query_occ) begin
      n.occ_flags = s.occurred | err_active;
      n.occurred = err_active;
      n.occ_valid = 1'b1;
    end
    if (ctrl_err > $signed(`ERR_LIMIT)) begin
      n.err_var = 13'(`ERR_LIMIT);
    end else if (ctrl_err < -$signed(`ERR_LIMIT)) begin
      n.err_var = 13'(-$signed(`ERR_LIMIT));
    end else begin
      n.err_var = 13'(ctrl_err);
    end
    if (boot_mode && host_link) begin
      n.hb_cnt = (s.hb_cnt == 25'(HB_PERIOD_CYC - 1)) ? 25'h0 : s.hb_cnt + 25'h1;
    end else begin
      n.hb_cnt = 25'h0;
    end
    // pulses at 0 and 2 pulse widths into each period
    blink = (n.hb_cnt < 25'(HB_PULSE_CYC)) ||
            (n.hb_cnt >= 25'(2 * HB_PULSE_CYC) && n.hb_cnt < 25'(3 * HB_PULSE_CYC));
    n.led = boot_mode && host_link && blink;
    if (!s.aw_done && !s.bvalid && s_axi_awvalid) begin
      n.aw_done = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (!s.w_done && !s.bvalid && s_axi_wvalid) begin
      n.w_done = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s.aw_done && s.w_done) begin
      n.aw_done = 1'b0;
      n.w_done = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `AXI_OKAY;
      case (s.aw_addr)
        `OFS_RESP: begin
          wr_word = merge({16'h0000, s.resp_cfg}, s.w_data, s.w_strb);
          n.resp_cfg = wr_word[15:0];
        end
        `OFS_CTRL: begin
          if (s.w_strb[0]) begin
            n.coast = s.w_data[`COAST_BIT];
          end
        end
        `OFS_STATUS, `OFS_OCC, `OFS_ERRVAR: begin
          n.bresp = `AXI_OKAY;
        end
        default: begin
          n.bresp = `AXI_SLVERR;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (!s.rvalid && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `AXI_OKAY;
      n.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `OFS_RESP:   n.rdata[15:0] = s.resp_cfg;
        `OFS_CTRL:   n.rdata[`COAST_BIT] = s.coast;
        `OFS_STATUS: begin
          n.rdata[7:0] = err_active;
          n.rdata[`STAT_AWAIT] = s.awaiting;
          n.rdata[`STAT_DRIVE] = drive_en;
          n.rdata[`STAT_OFF] = s.motor_off;
        end
        `OFS_OCC:    n.rdata[7:0] = s.occurred;
        `OFS_ERRVAR: n.rdata = 32'(s.err_var);
        default:     n.rresp = `AXI_SLVERR;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    // settings only; latched fault state survives a firmware swap
    if (fw_replace) begin
      n.resp_cfg = `RESP_RST;
      n.coast = `COAST_RST;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
      s.resp_cfg <= `RESP_RST;
      s.coast <= `COAST_RST;
    end else begin
      s <= n;
    end
  end

  assign drv.drive_en = drive_en;
  assign drv.coast = s.coast;
  assign drv.duty = duty_in;

  bridge_drive u_bridge (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .d          (drv),
    .out_a      (out_a),
    .out_a_oe   (out_a_oe),
    .out_b      (out_b),
    .out_b_oe   (out_b_oe)
  );

  assign s_axi_awready = !s.aw_done && !s.bvalid;
  assign s_axi_wready = !s.w_done && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign occ_flags = s.occ_flags;
  assign occ_valid = s.occ_valid;
  assign err_var = s.err_var;
  assign led_green = s.led;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  sequence latch_event;
    lat_hit;
  endsequence
  sequence no_target_2;
    !target_cmd [*2];
  endsequence

  AST_DISABLED_IGNORED: assert property (
    // full forward duty with nothing enabled active must reach the pins
    (rst_sync_n && (err_active & en_mask) == 8'h00 && !s.awaiting && !s.motor_off &&
     duty_in == 11'sd600) |=> out_a)
    else $error("disabled error stopped the motor");
  AST_OCC_RECORD: assert property (
    (err_active != 8'h00 && !query_occ) |=>
    ((s.occurred & $past(err_active)) == $past(err_active)))
    else $error("occurrence not recorded");
  AST_ENABLED_STOP: assert property (
    stop_now |=> (!out_a && !out_b))
    else $error("enabled error did not stop the motor");
  AST_LATCH_SET: assert property (
    latch_event |=> (s.awaiting && !drive_en))
    else $error("latched error did not set awaiting");
  AST_LATCH_HOLD: assert property (
    latch_event ##1 no_target_2 |-> (s.awaiting && !drive_en))
    else $error("motor restarted without a target command");
  AST_ERR_RANGE: assert property (
    (ctrl_err > $signed(`ERR_LIMIT)) |=> (s.err_var == 13'sh0fff))
    else $error("control error not clamped to 4095");
  AST_FW_DEFAULTS: assert property (
    fw_replace |=> (s.resp_cfg == `RESP_RST && s.coast == `COAST_RST))
    else $error("firmware replacement kept old settings");
  AST_HB_OFF: assert property (
    !(boot_mode && host_link) |=> !led_green)
    else $error("led blinks outside bootloader link");
  AST_TARGET_RESUME: assert property (
    (target_cmd && !lat_hit && !motor_off_cmd) |=> (!s.awaiting && !s.motor_off))
    else $error("target command did not clear awaiting");
endmodule

/* dv/host_model.sv */
// host side model: sends set-target commands and error-flag queries
module host_model (
  input  wire logic       mclk,
  output logic            target_cmd,
  output logic            query_occ,
  input  wire logic [7:0] occ_flags,
  input  wire logic       occ_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    target_cmd = 1'b0;
    query_occ = 1'b0;
  end
  // a latched stop is only lifted by this command, so the host owes it
  task automatic send_target();
    @(posedge mclk);
    target_cmd <= 1'b1;
    @(posedge mclk);
    target_cmd <= 1'b0;
  endtask
  // answer is a one-cycle pulse, so it is caught at the edge it stands
  task automatic query(output logic [7:0] f);
    @(posedge mclk);
    query_occ <= 1'b1;
    @(posedge mclk);
    query_occ <= 1'b0;
    do @(posedge mclk); while (occ_valid !== 1'b1);
    f = occ_flags;
  endtask
endmodule

/* dv/motor_error_response_tb_top.sv */
// self-checking bench for the motor error response block
`include "motor_error_response_cfg.svh"
module motor_error_response_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import motor_error_response_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, motor_off_cmd = 1'b0, fw_replace = 1'b0;
  logic        boot_mode = 1'b0, host_link = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        target_cmd, query_occ, occ_valid, led_green, out_a, out_a_oe, out_b, out_b_oe;
  logic        prv;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, err_active = 8'h00, occ_flags, fl;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic signed [15:0] ctrl_err = 16'sh0;
  logic signed [15:0] tin [5] = '{16'sd5000, -16'sd5000, 16'sd4095, -16'sd4096, -16'sd7};
  logic signed [12:0] tout [5] = '{13'sd4095, -13'sd4095, 13'sd4095, -13'sd4095, -13'sd7};
  duty_t       duty_in = 11'sh0;
  errvar_t     err_var;
  int          n_fail = 0, tests_run = 0, cyc = 0, ones, rises;

  motor_error_response #(.HB_PERIOD_CYC(100), .HB_PULSE_CYC(10)) uut (
    .mclk, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .err_active, .target_cmd, .motor_off_cmd, .query_occ, .occ_flags, .occ_valid,
    .duty_in, .ctrl_err, .err_var, .fw_replace, .boot_mode, .host_link, .led_green,
    .out_a, .out_a_oe, .out_b, .out_b_oe
  );
  host_model host (.mclk, .target_cmd, .query_occ, .occ_flags, .occ_valid);

  always #25 mclk = ~mclk;
  // a hung handshake would otherwise stall the run forever
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // pins as {a, a_oe, b, b_oe}; ends on an edge so drives stay edge aligned
  task automatic chk_pin(input logic [3:0] exp);
    repeat (3) @(posedge mclk);
    #1;
    chk({28'h0, out_a, out_a_oe, out_b, out_b_oe}, {28'h0, exp});
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1) @(posedge mclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata & m, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // one full led period: on-time and rising edges are phase independent
  task automatic led_win();
    repeat (20) @(posedge mclk);
    #1;
    prv = led_green;
    ones = 0;
    rises = 0;
    repeat (100) begin
      @(posedge mclk);
      #1;
      ones += int'(led_green === 1'b1);
      rises += int'(led_green === 1'b1 && prv === 1'b0);
      prv = led_green;
    end
    @(posedge mclk);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_pin(4'b0101);
    rd(`OFS_RESP, 32'hffffffff, 32'h5555, `AXI_OKAY);
    rd(`OFS_CTRL, 32'hffffffff, 32'h0, `AXI_OKAY);
    rd(8'h40, 32'hffffffff, 32'h0, `AXI_SLVERR);
    wr(8'h44, 32'h1, `AXI_SLVERR);
    // error 0 disabled, error 1 enabled, error 2 latched
    wr(`OFS_RESP, 32'h24, `AXI_OKAY);
    duty_in <= 11'sd600;
    chk_pin(4'b1101);
    err_active <= 8'h01;
    chk_pin(4'b1101);
    host.query(fl);
    chk({24'h0, fl}, 32'h01);
    err_active <= 8'h02;
    chk_pin(4'b0101);
    err_active <= 8'h00;
    chk_pin(4'b1101);
    err_active <= 8'h04;
    chk_pin(4'b0101);
    rd(`OFS_STATUS, 32'h100, 32'h100, `AXI_OKAY);
    // read-only words ignore writes; reads do not clear the occurred word
    wr(`OFS_OCC, 32'h0, `AXI_OKAY);
    rd(`OFS_OCC, 32'hff, 32'h07, `AXI_OKAY);
    // a target while the latched error is still active must be refused
    host.send_target();
    err_active <= 8'h00;
    chk_pin(4'b0101);
    host.send_target();
    chk_pin(4'b1101);
    rd(`OFS_STATUS, 32'h100, 32'h0, `AXI_OKAY);
    wr(`OFS_CTRL, 32'h1, `AXI_OKAY);
    @(posedge mclk);
    motor_off_cmd <= 1'b1;
    @(posedge mclk);
    motor_off_cmd <= 1'b0;
    chk_pin(4'b0000);
    rd(`OFS_STATUS, 32'h400, 32'h400, `AXI_OKAY);
    host.send_target();
    chk_pin(4'b1101);
    duty_in <= 11'sd0;
    chk_pin(4'b0000);
    wr(`OFS_CTRL, 32'h0, `AXI_OKAY);
    duty_in <= -11'sd600;
    chk_pin(4'b0111);
    for (int i = 0; i < 5; i++) begin
      ctrl_err <= tin[i];
      repeat (2) @(posedge mclk);
      #1;
      chk(32'(err_var), 32'(tout[i]));
      @(posedge mclk);
    end
    rd(`OFS_ERRVAR, 32'hffffffff, 32'hfffffff9, `AXI_OKAY);
    wr(`OFS_CTRL, 32'h1, `AXI_OKAY);
    @(posedge mclk);
    fw_replace <= 1'b1;
    @(posedge mclk);
    fw_replace <= 1'b0;
    rd(`OFS_RESP, 32'hffffffff, 32'h5555, `AXI_OKAY);
    rd(`OFS_CTRL, 32'hffffffff, 32'h0, `AXI_OKAY);
    boot_mode <= 1'b1;
    host_link <= 1'b1;
    led_win();
    chk(ones, 32'd20);
    chk(rises, 32'd2);
    host_link <= 1'b0;
    led_win();
    chk(ones, 32'd0);
    stop_test();
  end
endmodule
